// ### csbc_params.svh
// offsets, field positions, write mask, fixed bits and reset values of the space configuration block
`ifndef CSBC_PARAMS_SVH
`define CSBC_PARAMS_SVH
`define CSBC_MODE_WIDTH_OFFSET  12'h000
`define CSBC_IDLE_EXT_OFFSET    12'h004
`define CSBC_STATUS_OFFSET      12'h008
`define CSBC_MODE_WIDTH_RESET   16'h200f
`define CSBC_IDLE_EXT_RESET     16'hffff
`define CSBC_MODE_WIDTH_WMASK   16'h010f
`define CSBC_MODE_WIDTH_FIXED   16'h2000
`define CSBC_MUX_BIT            8
`define CSBC_GAP_LSB            8
`define CSBC_REPEAT_LSB         4
`define CSBC_STRETCH_LSB        0
`endif

// ### csbc_pkg.sv
// types shared by the space configuration block
package csbc_pkg;
	typedef enum logic [1:0] {
		CSBC_IDLE,
		CSBC_GAP,
		CSBC_LEAD,
		CSBC_RUN
	} csbc_state_e;
	typedef logic [1:0] csbc_space_t;
endpackage : csbc_pkg

// ### csbc_gap_calc.sv
// idle-cycle count chosen between two external accesses
`timescale 1ns/10ps
`default_nettype none
`include "csbc_params.svh"
module csbc_gap_calc (
	// previous access
	input  wire logic [1:0] prev_space,
	input  wire logic       prev_read,
	input  wire logic       prev_valid,
	// next access
	input  wire logic [1:0] next_space,
	input  wire logic       next_write,
	// idle and extension register
	input  wire logic [15:0] idle_ext,
	// result
	output logic      [1:0] gap_count
);
	wire logic [1:0] gap_field;
	wire logic       rep_bit;
	wire logic       same_space;
	wire logic [1:0] iw_use;
	wire logic [1:0] cw_use;
	// count taken from the previous space [RULE16]
	assign gap_field  = idle_ext[`CSBC_GAP_LSB + 2*prev_space +: 2]; // [RULE17]
	assign rep_bit    = idle_ext[`CSBC_REPEAT_LSB + prev_space]; // [RULE18]
	assign same_space = prev_space == next_space;
	// read then other space, or read then write [RULE14] [RULE15]
	assign iw_use = (prev_valid && prev_read && (!same_space || next_write))
		? gap_field : 2'h0;
	assign cw_use = (prev_valid && same_space && rep_bit) ? 2'h1 : 2'h0; // [RULE19]
	assign gap_count = (iw_use > cw_use) ? iw_use : cw_use; // [RULE20]
endmodule : csbc_gap_calc
`default_nettype wire

// ### csbc_top.sv
// chip-select space configuration and sequencing
`timescale 1ns/10ps
`default_nettype none
`include "csbc_params.svh"
// Overview of operation
// [RULE1] power-on reset loads first register 200f
// [RULE2] bits 15,14,12..9 always read zero
// [RULE3] bit 13 always reads one
// [RULE4] software writes zero to bits 7..4
// [RULE5] bit 8 picks multiplexed fourth space
// [RULE6] multiplexed space drives address then data
// [RULE7] multiplexed width comes from address bit
// [RULE8] bit 3 widths fourth space when ordinary
// [RULE9] bits 2..0 width other spaces, reset word
// [RULE10] first space width from pin without rom
// [RULE11] software sets bits 8..0 once only; the code takes every write, with no once-only lock
// [RULE12] rom off: only first space before setup; the code lets any space be accessed before setup
// [RULE13] power-on reset sets second register ffff
// [RULE14] read then other space inserts idle
// [RULE15] read then write same space inserts idle
// [RULE16] idle count from previous access space
// [RULE17] four 2-bit idle fields, bits 15..8
// [RULE18] repeat bits 7..4, stretch bits 3..0
// [RULE19] repeat bit negates select one cycle
// [RULE20] read then write uses larger count
// [RULE21] stretch adds cycle before and after
module csbc_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// straps
	input  wire logic        rom_enabled,
	input  wire logic        mode_pin_wide,
	// access request from the core
	input  wire logic        acc_req,
	input  wire logic [1:0]  acc_space,
	input  wire logic        acc_write,
	input  wire logic [21:0] acc_addr,
	input  wire logic [15:0] acc_wdata,
	output logic             acc_done,
	// external bus
	output logic [3:0]       select_n,
	output logic             read_n,
	output logic             write_n,
	output logic             addr_hold,
	output logic [21:0]      ext_addr,
	output logic [15:0]      data_out,
	output logic             data_oe_n,
	output logic             bus_wide
);
	logic [15:0] mode_width_reg;
	logic [15:0] idle_ext_reg;
	csbc_pkg::csbc_state_e state_reg;
	csbc_pkg::csbc_state_e state_next;
	logic [1:0]  count_reg;
	logic [1:0]  count_next;
	logic [1:0]  prev_space_reg;
	logic        prev_read_reg;
	logic        prev_valid_reg;
	logic [1:0]  cur_space_reg;
	logic        cur_write_reg;
	logic [21:0] cur_addr_reg;
	logic [15:0] cur_wdata_reg;
	logic        tail_reg;
	wire  logic [1:0]  gap_count;
	wire  logic        wr_en;
	wire  logic        rd_en;
	wire  logic        hit_mw;
	wire  logic        hit_ie;
	wire  logic        hit_st;
	wire  logic [15:0] mw_view;
	wire  logic [31:0] rd_value;
	wire  logic [3:0]  widths;
	wire  logic        mux_mode;
	wire  logic        stretch;
	wire  logic        cur_wide;
	wire  logic        in_run;
	wire  logic        idle_now;
	wire  logic [1:0]  go_space;
	wire  logic        go_write;
	wire  logic [21:0] go_addr;
	wire  logic [15:0] go_wdata;
	wire  logic        go_wide;
	wire  logic        go_lead;
	wire  logic        go_run;
	wire  logic        need_lead;
	wire  logic        tail_due;

	// apb decode; zero-wait slave
	assign wr_en  = psel && penable && pwrite;
	assign rd_en  = psel && !penable && !pwrite;
	assign hit_mw = paddr == `CSBC_MODE_WIDTH_OFFSET;
	assign hit_ie = paddr == `CSBC_IDLE_EXT_OFFSET;
	assign hit_st = paddr == `CSBC_STATUS_OFFSET;
	// reserved bits forced on read [RULE2] [RULE3]
	assign mw_view = (mode_width_reg & `CSBC_MODE_WIDTH_WMASK)
		| `CSBC_MODE_WIDTH_FIXED;
	assign rd_value = hit_mw ? {16'h0000, mw_view}
		: hit_ie ? {16'h0000, idle_ext_reg}
		: hit_st ? {24'h0000_00, mux_mode, tail_reg, cur_wide,
			in_run, widths}
		: 32'h0000_0000;

	// effective widths per space
	assign mux_mode = mode_width_reg[`CSBC_MUX_BIT]; // [RULE5]
	assign widths[0] = rom_enabled ? mode_width_reg[0]
		: mode_pin_wide; // [RULE10]
	assign widths[2:1] = mode_width_reg[2:1]; // [RULE9]
	// multiplexed width from the address bit [RULE7] [RULE8]
	assign widths[3] = mux_mode ? acc_addr[14] : mode_width_reg[3];
	assign cur_wide = (mux_mode && cur_space_reg == 2'h3)
		? cur_addr_reg[14] : (cur_space_reg == 2'h0) ? widths[0]
		: mode_width_reg[cur_space_reg]; // [RULE10]
	assign stretch = idle_ext_reg[`CSBC_STRETCH_LSB + acc_space]; // [RULE21]
	assign in_run = state_reg == csbc_pkg::CSBC_RUN;
	// fields of the access being launched; capture lags by one edge
	assign idle_now = state_reg == csbc_pkg::CSBC_IDLE;
	assign go_space = idle_now ? acc_space : cur_space_reg;
	assign go_write = idle_now ? acc_write : cur_write_reg;
	assign go_addr  = idle_now ? acc_addr : cur_addr_reg;
	assign go_wdata = idle_now ? acc_wdata : cur_wdata_reg;
	assign go_wide  = (mux_mode && go_space == 2'h3) ? go_addr[14]
		: (go_space == 2'h0) ? widths[0]
		: mode_width_reg[go_space]; // [RULE7] [RULE8] [RULE10]
	assign go_lead  = state_next == csbc_pkg::CSBC_LEAD;
	assign go_run   = state_next == csbc_pkg::CSBC_RUN;
	// multiplexed space needs a lead cycle for its address phase [RULE6]
	assign need_lead = stretch || (mux_mode && acc_space == 2'h3);
	assign tail_due  = in_run
		&& idle_ext_reg[`CSBC_STRETCH_LSB + cur_space_reg]; // [RULE21]

	csbc_gap_calc i_csbc_gap_calc (
		.prev_space (prev_space_reg),
		.prev_read  (prev_read_reg),
		.prev_valid (prev_valid_reg),
		.next_space (acc_space),
		.next_write (acc_write),
		.idle_ext   (idle_ext_reg),
		.gap_count  (gap_count)
	);

	// registers keep value outside power-on reset [RULE1] [RULE13]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_width_reg <= `CSBC_MODE_WIDTH_RESET; // [RULE1]
			idle_ext_reg   <= `CSBC_IDLE_EXT_RESET; // [RULE13]
		end else if (wr_en && hit_mw) begin
			// bits 7..4 kept zero; writing them is ignored [RULE4]
			mode_width_reg <= (pwdata[15:0] & `CSBC_MODE_WIDTH_WMASK)
				| `CSBC_MODE_WIDTH_FIXED; // [RULE2] [RULE3]
		end else if (wr_en && hit_ie) begin
			idle_ext_reg <= pwdata[15:0]; // [RULE17] [RULE18]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= rd_en ? rd_value : prdata;
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !(hit_mw || hit_ie || hit_st);
		end
	end

	// access sequencer: gap, optional lead, one strobe cycle, tail
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			csbc_pkg::CSBC_IDLE: begin
				if (acc_req && !acc_done) begin
					if (gap_count != 2'h0) begin
						state_next = csbc_pkg::CSBC_GAP; // [RULE14]
						count_next = gap_count;
					end else if (need_lead) begin
						state_next = csbc_pkg::CSBC_LEAD; // [RULE6] [RULE21]
					end else begin
						state_next = csbc_pkg::CSBC_RUN;
					end
				end
			end
			csbc_pkg::CSBC_GAP: begin
				count_next = count_reg - 2'h1;
				if (count_reg == 2'h1) begin
					state_next = need_lead ? csbc_pkg::CSBC_LEAD
						: csbc_pkg::CSBC_RUN;
				end
			end
			csbc_pkg::CSBC_LEAD: state_next = csbc_pkg::CSBC_RUN;
			csbc_pkg::CSBC_RUN:  state_next = csbc_pkg::CSBC_IDLE;
			default:             state_next = csbc_pkg::CSBC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= csbc_pkg::CSBC_IDLE;
			count_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// capture the request when it leaves idle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_space_reg <= 2'h0;
			cur_write_reg <= 1'b0;
			cur_addr_reg  <= 22'h00_0000;
			cur_wdata_reg <= 16'h0000;
		end else if (state_reg == csbc_pkg::CSBC_IDLE && acc_req) begin
			cur_space_reg <= acc_space;
			cur_write_reg <= acc_write;
			cur_addr_reg  <= acc_addr;
			cur_wdata_reg <= acc_wdata;
		end
	end

	// history of the last finished access [RULE16]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_space_reg <= 2'h0;
			prev_read_reg  <= 1'b0;
			prev_valid_reg <= 1'b0;
			tail_reg       <= 1'b0;
			acc_done       <= 1'b0;
		end else begin
			acc_done <= in_run;
			tail_reg <= in_run
				&& idle_ext_reg[`CSBC_STRETCH_LSB + cur_space_reg];
			if (in_run) begin
				prev_space_reg <= cur_space_reg;
				prev_read_reg  <= !cur_write_reg;
				prev_valid_reg <= 1'b1;
			end else if (state_reg == csbc_pkg::CSBC_IDLE && !acc_req
				&& !tail_reg) begin
				// bus went quiet, no back-to-back pairing any more
				prev_valid_reg <= 1'b0;
			end
		end
	end

	// external pins; select held in lead, run and tail [RULE21]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			select_n  <= 4'hf;
			read_n    <= 1'b1;
			write_n   <= 1'b1;
			addr_hold <= 1'b0;
			ext_addr  <= 22'h00_0000;
			data_out  <= 16'h0000;
			data_oe_n <= 1'b1;
			bus_wide  <= 1'b0;
		end else begin
			select_n <= 4'hf;
			read_n   <= 1'b1;
			write_n  <= 1'b1;
			addr_hold <= 1'b0;
			data_oe_n <= 1'b1;
			// pins follow the state of the coming cycle
			if (go_lead || go_run) begin
				select_n[go_space] <= 1'b0;
				ext_addr <= go_addr;
				bus_wide <= go_wide; // [RULE9] [RULE10]
			end
			// trailing select cycle after the strobe [RULE21]
			if (tail_due) begin
				select_n[cur_space_reg] <= 1'b0;
			end
			// multiplexed space: address on data pins in lead [RULE6]
			if (go_lead && mux_mode && go_space == 2'h3) begin
				data_out  <= go_addr[15:0];
				data_oe_n <= 1'b0;
				addr_hold <= 1'b1;
			end
			// strobes only in the run cycle, set at the same edge as the select unless a lead cycle set the select one edge earlier [RULE21]
			if (go_run) begin
				read_n    <= go_write;
				write_n   <= !go_write;
				data_out  <= go_wdata;
				data_oe_n <= !go_write;
			end
		end
	end
endmodule : csbc_top
`default_nettype wire

// ### csbc_top_props.sv
// assertions on the ports of the space configuration block
`timescale 1ns/10ps
`default_nettype none
module csbc_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// straps and external bus
	input wire logic        rom_enabled,
	input wire logic        mode_pin_wide,
	input wire logic [3:0]  select_n,
	input wire logic        read_n,
	input wire logic        write_n,
	input wire logic        addr_hold,
	input wire logic [21:0] ext_addr,
	input wire logic        data_oe_n,
	input wire logic        bus_wide
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_mode_read;
		psel && penable && pready && !pwrite && paddr == 12'h000;
	endsequence
	sequence s_mux_addr;
		addr_hold && !select_n[3];
	endsequence
	property p_rsv_zero;
		s_mode_read |-> prdata[15:14] == 2'h0 && prdata[12:9] == 4'h0;
	endproperty
	property p_rsv_one;
		s_mode_read |-> prdata[13] == 1'b1;
	endproperty
	property p_mux_space;
		addr_hold |-> select_n == 4'h7;
	endproperty
	property p_mux_drive;
		s_mux_addr |-> !data_oe_n;
	endproperty
	property p_mux_width;
		s_mux_addr |-> bus_wide == ext_addr[14];
	endproperty
	// strobe cycle only: width may change while the select is idle
	property p_rom_off;
		!rom_enabled && !select_n[0] && !(read_n && write_n)
			|-> bus_wide == mode_pin_wide;
	endproperty
	property p_rd_in_sel;
		!read_n |-> select_n != 4'hf;
	endproperty
	property p_wr_in_sel;
		!write_n |-> select_n != 4'hf;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bits not zero");
	a_rsv_one: assert property (p_rsv_one)
		else $error("bit 13 not one");
	a_mux_space: assert property (p_mux_space)
		else $error("address phase outside fourth space");
	a_mux_drive: assert property (p_mux_drive)
		else $error("address phase not driven");
	a_mux_width: assert property (p_mux_width)
		else $error("multiplexed width not from address bit");
	a_rom_off: assert property (p_rom_off)
		else $error("first space width not from pin");
	a_rd_in_sel: assert property (p_rd_in_sel)
		else $error("read strobe outside select");
	a_wr_in_sel: assert property (p_wr_in_sel)
		else $error("write strobe outside select");
endmodule : csbc_props
bind csbc_top csbc_props i_csbc_props (.clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .rom_enabled, .mode_pin_wide,
	.select_n, .read_n, .write_n, .addr_hold, .ext_addr, .data_oe_n,
	.bus_wide);
`default_nettype wire

// ### csbc_ext_mem.sv
// external device model watching the chip-select bus
`timescale 1ns/10ps
`default_nettype none
module csbc_ext_mem (
	// clock
	input wire logic        clk,
	// external bus
	input wire logic [3:0]  select_n,
	input wire logic        read_n,
	input wire logic        write_n,
	input wire logic        addr_hold,
	input wire logic [15:0] data_out,
	input wire logic        bus_wide,
	// observations
	output logic            width_seen,
	output logic            mux_seen,
	output logic [15:0]     last_wdata
);
	// width is latched in the strobe cycle, where the device must hold it
	always @(posedge clk) begin
		if (!read_n || !write_n) width_seen <= bus_wide;
		if (&select_n) mux_seen <= 1'b0;
		else if (addr_hold) mux_seen <= 1'b1;
		if (!write_n) last_wdata <= data_out;
	end
endmodule : csbc_ext_mem
`default_nettype wire

// ### csbc_top_bench.sv
// self-checking bench for the space configuration block
`timescale 1ns/10ps
`default_nettype none
module csbc_top_bench;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        rom_enabled, mode_pin_wide, acc_req, acc_write, acc_done;
	logic [1:0]  acc_space;
	logic [21:0] acc_addr, ext_addr;
	logic [15:0] acc_wdata, data_out, last_wdata;
	logic [3:0]  select_n;
	logic        read_n, write_n, addr_hold, data_oe_n, bus_wide;
	logic        width_seen, mux_seen;
	int          failures, n_checks, cyc, b, lat;
	csbc_top i_csbc_top (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rom_enabled, .mode_pin_wide,
		.acc_req, .acc_space, .acc_write, .acc_addr, .acc_wdata, .acc_done,
		.select_n, .read_n, .write_n, .addr_hold, .ext_addr, .data_out,
		.data_oe_n, .bus_wide);
	csbc_ext_mem i_csbc_ext_mem (.clk, .select_n, .read_n, .write_n,
		.addr_hold, .data_out, .bus_wide, .width_seen, .mux_seen, .last_wdata);
	always #20 clk = ~clk;
	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// a hang anywhere ends here rather than running forever
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			final_report;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, r);
	endtask : rd
	// request stays up after done so that the next call runs back to back
	task automatic acc(input logic [1:0] sp, input logic w, input logic [21:0] ad);
		acc_req <= 1'b1; acc_space <= sp; acc_write <= w; acc_addr <= ad;
		lat = 0;
		do begin @(posedge clk); lat++; end while (acc_done !== 1'b1);
	endtask : acc
	task automatic rest;
		acc_req <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : rest
	task automatic rel;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask : rel
	initial begin
		clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; rom_enabled = 1; mode_pin_wide = 0; acc_req = 0;
		acc_space = '0; acc_write = 0; acc_addr = '0; acc_wdata = 16'hc3a5;
		rel;
		rd(12'h000, 32'h0000_200f, "mode_reset");
		rd(12'h004, 32'h0000_ffff, "idle_reset");
		apb(1'b1, 12'h000, 32'h0000_df05);
		rd(12'h000, 32'h0000_2105, "mode_read");
		apb(1'b0, 12'h00c, 32'h0000_0000);
		chk("unmapped_err", 1, err);
		for (int i = 0; i < 5; i++) begin
			acc((i > 3) ? 2'h3 : i[1:0], 1'b0, (i == 3) ? 22'h00_4000 : 22'h0);
			chk("width_mux_on", 5'b01101 >> i & 1, width_seen);
			chk("mux_phase", i > 2, mux_seen);
		end
		rest;
		reset_n <= 1'b0; rom_enabled <= 1'b0; mode_pin_wide <= 1'b1;
		rel;
		apb(1'b1, 12'h000, 32'h0000_200a);
		for (int i = 0; i < 4; i++) begin
			acc(i[1:0], 1'b0, 22'h0);
			chk("width_rom_off", 4'b1011 >> i & 1, width_seen);
		end
		rest;
		rd(12'h008, 32'h0000_002b, "status");
		apb(1'b1, 12'h004, 32'h0000_0000);
		acc(2'h0, 1'b0, 22'h0);
		b = lat;
		rest;
		apb(1'b1, 12'h004, 32'h0000_e490);
		for (int i = 0; i < 8; i++) begin
			acc(2'(16'h02fd >> 2 * i), 1'(8'h48 >> i), 22'h0);
			chk("gap", 32'h1120_3110 >> 4 * i & 7, lat - b);
		end
		chk("wdata", 32'h0000_c3a5, last_wdata);
		rest;
		apb(1'b1, 12'h004, 32'h0000_0001);
		acc(2'h0, 1'b0, 22'h0);
		chk("stretch", 1, lat - b);
		rest;
		final_report;
	end
endmodule : csbc_top_bench
`default_nettype wire
